// ==== hdl/serial_adc_readout_port.sv ====
// Digital side of the converter: frame control and serial readout
module serial_adc_readout_port
   import adc_readout_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic frame_sel_n_i, // Active-low frame select pin
   input wire logic sclk_i, // Serial clock pin, sampled
   input wire logic [adc_readout_pkg::RES_W-1:0] analog_code_i, // Quantised input
   output logic sample_out_line_o, // Serial data out
   output logic sample_out_line_oe_n_o, // Low while driving
   output logic hold_o, // High in hold, low in track
   output logic shutdown_o, // Shutdown mode flag
   output logic powered_o // Analog fully powered
);
   import adc_readout_pkg::*;

   edge_if cs_e ();
   edge_if ck_e ();

   // Select pin idles high
   pin_sync #(.RST_VAL(1'b1)) u_cs_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(frame_sel_n_i),
      .sig(cs_e)
   );
   // Serial clock sampled like any pin
   pin_sync #(.RST_VAL(1'b0)) u_ck_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(sclk_i),
      .sig(ck_e)
   );

   // Sequencer and timing registers
   frame_state_t state_r, state_nxt; // Frame sequencer
   logic [4:0] falls_r, falls_nxt; // Falling edges since select fell
   logic [4:0] rises_r, rises_nxt; // Rising edges since select fell
   logic [RES_W-1:0] held_r, held_nxt; // Sampled input
   logic dout_r, dout_nxt; // Bit standing on the data line
   logic oe_n_r, oe_n_nxt; // Line driver, low while driving
   logic hold_r, hold_nxt; // Hold switch, high in hold
   logic shdn_r, shdn_nxt; // Shutdown mode
   logic mode_was_r, mode_was_nxt; // Mode in force before this frame
   logic pwr_r, pwr_nxt; // Analog fully powered
   logic [5:0] pwr_cnt_r, pwr_cnt_nxt; // Power-up timer
   logic [RES_W-1:0] trial; // Kept trial bits so far
   logic [RES_W-1:0] trial_mask; // Bit now under trial

   // Named frame events
   logic frame_start; // Detected select fall
   logic frame_stop; // Detected select rise
   logic frame_open; // Select fall that opens a frame
   logic sel_high; // Select settled high
   logic in_frame; // Sequencer inside a frame
   logic sclk_fall; // Serial clock fall inside a frame
   logic sclk_rise; // Serial clock rise inside a frame
   logic last_fall; // Sixteenth fall of the frame
   logic track_rise; // Thirteenth rise of the frame
   logic result_phase; // Fall that launches a result bit
   logic early_rise; // Select rose before the second fall
   logic shdn_rise; // Select rose inside the shutdown window
   logic sar_step; // One trial per serial clock fall
   logic [4:0] out_pos; // Result bit launched on this fall
   logic result_bit; // Settled comparator bit for this fall

   // Select events
   assign frame_start = cs_e.fall;
   assign frame_stop = cs_e.rise;
   assign sel_high = cs_e.level;
   assign in_frame = (state_r == ST_CONV);
   assign frame_open = frame_start && (state_r == ST_IDLE);
   // Serial clock edges count only inside a frame
   assign sclk_fall = in_frame && ck_e.fall;
   assign sclk_rise = in_frame && ck_e.rise;
   assign last_fall = sclk_fall && (falls_r == FRAME_FALLS - 5'h01);
   assign track_rise = sclk_rise && (rises_r == TRACK_RISE - 5'h01);
   // Falls four to fifteen each launch one result bit
   assign result_phase = sclk_fall && !last_fall && (falls_r >= LEAD_ZEROS - 5'h01);
   // Where the select rise lands decides the mode
   assign early_rise = frame_stop && in_frame && (falls_r < SHDN_MIN_FALL);
   assign shdn_rise = frame_stop && in_frame && (falls_r >= SHDN_MIN_FALL)
                      && (falls_r < SHDN_MAX_FALL);
   assign sar_step = sclk_fall && !shdn_r;
   // Fall k launches bit 15-k; by then k-1 trials are done, so the bit
   // settled three falls earlier and the output never waits for the LSB
   assign out_pos = FRAME_FALLS - 5'h02 - falls_r;
   // Out-of-range positions only occur outside the result phase
   assign result_bit = (out_pos < 5'(RES_W)) ? trial[out_pos[3:0]] : 1'b0;

   // Conversion timed by the serial clock
   sar_core u_sar (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(frame_start),
      .step_i(sar_step),
      .sample_i(held_r),
      .trial_o(trial),
      .mask_o(trial_mask)
   );

   // Frame sequencer and output path
   always_comb begin
      // Hold every register unless a branch moves it
      state_nxt = state_r;
      falls_nxt = falls_r;
      rises_nxt = rises_r;
      held_nxt = held_r;
      dout_nxt = dout_r;
      oe_n_nxt = oe_n_r;
      hold_nxt = hold_r;
      case (state_r)
         ST_IDLE: begin
            // Wait for select to fall
            if (frame_start) begin
               state_nxt = ST_CONV;
               falls_nxt = 5'h00;
               rises_nxt = 5'h00;
               held_nxt = analog_code_i;
               hold_nxt = 1'b1;
               oe_n_nxt = 1'b0;
               // First zero stands before any clock edge arrives
               dout_nxt = 1'b0;
            end
         end
         ST_CONV: begin
            // Rises only count and move the hold switch
            if (sclk_rise) begin
               rises_nxt = rises_r + 5'h01;
            end
            // Back to track on the thirteenth rise
            if (track_rise) begin
               hold_nxt = 1'b0;
            end
            if (frame_stop) begin
               // Select rose early: abort and release
               state_nxt = ST_IDLE;
               oe_n_nxt = 1'b1;
               hold_nxt = 1'b0;
            end else if (last_fall) begin
               // Sixteenth fall ends the word
               falls_nxt = falls_r + 5'h01;
               state_nxt = ST_DONE;
               oe_n_nxt = 1'b1;
            end else if (result_phase) begin
               // Launch the bit the comparator settled earlier
               falls_nxt = falls_r + 5'h01;
               dout_nxt = result_bit;
            end else if (sclk_fall) begin
               // Leading zeros ahead of the result
               falls_nxt = falls_r + 5'h01;
               dout_nxt = 1'b0;
            end
         end
         ST_DONE: begin
            // Released; a select held low must rise before a new frame
            if (sel_high) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            // Unused code falls back to idle
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Mode decision: select low wakes the device, the rise point decides
   always_comb begin
      // Nothing else moves the mode, so shutdown lasts until select falls
      shdn_nxt = shdn_r;
      mode_was_nxt = mode_was_r;
      if (frame_open) begin
         // Remember the old mode in case this frame is cut too soon
         mode_was_nxt = shdn_r;
         shdn_nxt = 1'b0;
      end else if (shdn_rise) begin
         shdn_nxt = 1'b1;
      end else if (early_rise) begin
         // Too short to count as a mode request; guards against glitches
         shdn_nxt = mode_was_r;
      end else if (frame_stop && in_frame) begin
         // Past the tenth fall: word truncated, normal mode kept
         shdn_nxt = 1'b0;
      end
   end

   // Power-up timer after a shutdown exit or reset
   always_comb begin
      pwr_nxt = pwr_r;
      pwr_cnt_nxt = pwr_cnt_r;
      if (shdn_nxt) begin
         // Follows the mode on the same edge, so both flags agree
         pwr_nxt = 1'b0;
         pwr_cnt_nxt = 6'h00;
      end else if (!pwr_r) begin
         if (pwr_cnt_r == 6'(POWERUP_CYC - 1)) begin
            pwr_nxt = 1'b1;
         end else begin
            pwr_cnt_nxt = pwr_cnt_r + 6'h01;
         end
      end
   end

   // Frame sequencer registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         // Done; select level resets high, so a select held low at release still opens a frame
         state_r <= ST_DONE;
         falls_r <= 5'h00;
         rises_r <= 5'h00;
      end else begin
         state_r <= state_nxt;
         falls_r <= falls_nxt;
         rises_r <= rises_nxt;
      end
   end

   // Sampled input, held for the whole conversion
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         held_r <= RES_RST;
      end else begin
         held_r <= held_nxt;
      end
   end

   // Data line and its driver
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         // Released out of reset
         dout_r <= 1'b0;
         oe_n_r <= 1'b1;
      end else begin
         dout_r <= dout_nxt;
         oe_n_r <= oe_n_nxt;
      end
   end

   // Track and hold switch
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hold_r <= 1'b0;
      end else begin
         hold_r <= hold_nxt;
      end
   end

   // Mode and the mode before the current frame
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shdn_r <= 1'b0;
         mode_was_r <= 1'b0;
      end else begin
         shdn_r <= shdn_nxt;
         mode_was_r <= mode_was_nxt;
      end
   end

   // Power state and its timer
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         // Reset counts as a fresh power-up
         pwr_r <= 1'b0;
         pwr_cnt_r <= 6'h00;
      end else begin
         pwr_r <= pwr_nxt;
         pwr_cnt_r <= pwr_cnt_nxt;
      end
   end

   // Every output straight from its register
   assign sample_out_line_o = dout_r;
   assign sample_out_line_oe_n_o = oe_n_r;
   assign hold_o = hold_r;
   assign shutdown_o = shdn_r;
   assign powered_o = pwr_r;
endmodule

// ==== include/adc_readout_pkg.sv ====
// Notes on behaviour
// - Full frame is sixteen serial clock periods.
// - Select fall samples, holds, starts, drives output.
// - Back to track on thirteenth rising edge.
// - Release output after sixteenth fall or select rise.
// - Bits launched on falling edges, captured next fall.
// - Four zeros then twelve bits, MSB first.
// - Falling first edge may spoil first zero.
// - Result is straight unsigned binary.
// - Select rise after second, before tenth fall shuts down.
// - Shutdown holds until select next falls.
// - Serial clock alone times conversion and output.
// - Edge counts restart at each select fall.
// - Rise before second fall keeps mode, aborts.
// - Rise after tenth fall keeps normal, truncates.
package adc_readout_pkg;
   localparam int CLK_HZ = 40_000_000; // Block clock rate
   localparam int QUIET_NS = 50; // Least inter_frame_gap, host side
   localparam int QUIET_CYC = (QUIET_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int POWERUP_NS = 1000; // Typical power-up time
   localparam int POWERUP_CYC = (POWERUP_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam logic [4:0] FRAME_FALLS = 5'h10; // Falls per frame_duration
   localparam logic [4:0] TRACK_RISE = 5'h0D; // Rising edge back to track
   localparam logic [4:0] SHDN_MIN_FALL = 5'h02; // Earliest fall for shutdown
   localparam logic [4:0] SHDN_MAX_FALL = 5'h0A; // Fall that locks normal mode
   localparam logic [4:0] LEAD_ZEROS = 5'h04; // Zero bits ahead of result
   localparam int RES_W = 12; // Result width
   localparam logic [RES_W-1:0] RES_RST = 12'h000; // Result reset value
   // Frame sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b10
   } frame_state_t;
endpackage

// ==== include/edge_if.sv ====
// Synchronised pin levels and their edges
interface edge_if;
   logic level; // Filtered level
   logic rise; // One-cycle pulse on rising change
   logic fall; // One-cycle pulse on falling change
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface

// ==== hdl/pin_sync.sv ====
// Three-stage pin sampler; change counts when stages two and three agree
module pin_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   edge_if.src sig
);
   logic s1_r; // Metastability stage, read only by s2_r
   logic s2_r;
   logic s3_r;
   logic lvl_r; // Accepted level
   logic agree;
   assign agree = (s2_r == s3_r);
   // Shift chain
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   // Accept only agreed levels
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lvl_r <= RST_VAL;
      end else if (agree) begin
         lvl_r <= s3_r;
      end
   end
   assign sig.level = lvl_r;
   assign sig.rise = agree && s3_r && !lvl_r;
   assign sig.fall = agree && !s3_r && lvl_r;
endmodule

// ==== hdl/sar_core.sv ====
// Successive approximation: one trial bit per serial clock fall
module sar_core
   import adc_readout_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i, // Frame begins, sample held
   input wire logic step_i, // One trial per pulse
   input wire logic [adc_readout_pkg::RES_W-1:0] sample_i, // Held input
   output logic [adc_readout_pkg::RES_W-1:0] trial_o, // Current trial word
   output logic [adc_readout_pkg::RES_W-1:0] mask_o // Bit under trial
);
   logic [RES_W-1:0] trial_r;
   logic [RES_W-1:0] mask_r;
   logic [RES_W-1:0] probe;
   logic keep;
   // Comparator: keep bit when trial does not exceed input
   assign probe = trial_r | mask_r;
   assign keep = (probe <= sample_i);
   // Trial register advances only on serial clock steps
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         trial_r <= RES_RST;
         mask_r <= RES_RST;
      end else if (start_i) begin
         trial_r <= RES_RST;
         mask_r <= {1'b1, {(RES_W-1){1'b0}}};
      end else if (step_i && mask_r != RES_RST) begin
         trial_r <= keep ? probe : trial_r;
         mask_r <= mask_r >> 1;
      end
   end
   assign trial_o = trial_r;
   assign mask_o = mask_r;
endmodule

// ==== bench/serial_adc_readout_port_assertions.sv ====
module serial_adc_readout_port_assertions
   import adc_readout_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic frame_sel_n_i,
   input wire logic sclk_i,
   input wire logic [adc_readout_pkg::RES_W-1:0] analog_code_i,
   input wire logic sample_out_line_o,
   input wire logic sample_out_line_oe_n_o,
   input wire logic hold_o,
   input wire logic shutdown_o,
   input wire logic powered_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // One domain: block clock, async reset
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Frame opening on the pin
   sequence sel_fall;
      $fell(frame_sel_n_i);
   endsequence
   // Driver on for two cycles running
   sequence drive_on;
      !sample_out_line_oe_n_o [*2];
   endsequence
   // Sync delay means the pin fall is a few cycles back
   sequence sclk_was_low;
      !$past(sclk_i, 3) || !$past(sclk_i, 4) || !$past(sclk_i, 5);
   endsequence
   AST_OE_ON: assert property (sel_fall |-> ##[1:8] drive_on)
      else $error("driver not on after select fall");
   AST_HOLD_ON: assert property (sel_fall |-> ##[1:8] hold_o)
      else $error("no hold after select fall");
   AST_REL_RISE: assert property ($rose(frame_sel_n_i) |-> ##[1:8] sample_out_line_oe_n_o)
      else $error("driver kept after select rise");
   AST_IDLE_OFF: assert property (frame_sel_n_i [*8] |-> sample_out_line_oe_n_o)
      else $error("driver on outside frame");
   AST_LAUNCH: assert property (($changed(sample_out_line_o) && !sample_out_line_oe_n_o
      && !$past(sample_out_line_oe_n_o)) |-> sclk_was_low)
      else $error("bit changed without clock fall");
   AST_TRACK: assert property (($rose(sample_out_line_oe_n_o) && !frame_sel_n_i) |-> !hold_o)
      else $error("still in hold at end of frame");
   AST_SHUT_KEEP: assert property ((shutdown_o && frame_sel_n_i) |=> shutdown_o)
      else $error("shutdown left without select fall");
   AST_PWR_OFF: assert property (shutdown_o |-> !powered_o)
      else $error("powered while in shutdown");
endmodule

// ==== bench/host_model.sv ====
// Host side: frames the select and makes the serial clock
module host_model (
   input wire logic clk_i,
   input wire logic line_i,
   input wire logic oe_n_i,
   output logic sel_n_o,
   output logic sclk_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic last_q = 1'b0; // Last level the device drove
   wire logic seen; // Level at the host pin
   // Released line has no pull: show the inverse, never a stale bit
   assign seen = oe_n_i ? ~last_q : line_i;
   always @(posedge clk_i) begin
      if (!oe_n_i) begin
         last_q <= line_i;
      end
   end
   initial begin
      sel_n_o = 1'b1;
      sclk_o = 1'b0;
   end
   // Half of a 200 ns serial clock
   task automatic half;
      repeat (4) @(negedge clk_i);
   endtask
   // Frame of up to sixteen falls; clock stands still outside it
   task automatic frame(input int falls, input bit idle_hi, output logic [15:0] word);
      word = 16'hFFFF;
      sclk_o = idle_hi;
      half();
      sel_n_o = 1'b0;
      half();
      for (int k = 1; k <= 16; k++) begin
         if (k > 1 || !idle_hi) begin
            sclk_o = 1'b1;
            half();
         end
         sclk_o = 1'b0;
         word = {word[14:0], seen};
         if (k == falls) begin
            if (k == 16) begin
               half();
            end
            break;
         end
         half();
      end
      half();
      sel_n_o = 1'b1;
      sclk_o = idle_hi;
      repeat (12) @(negedge clk_i);
   endtask
endmodule

// ==== bench/serial_adc_readout_port_tb_top.sv ====
module serial_adc_readout_port_tb_top import adc_readout_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0; // Block clock
   logic rst_i = 1'b1; // Held eight cycles
   logic [RES_W-1:0] code = 12'h000; // Quantised input
   logic sel_n, sclk, line, oe_n, hold, shut, pwr; // Pins and flags
   logic [15:0] w; // Captured frame word
   int error_cnt = 0;
   int n_compared = 0;
   // 40 MHz block clock
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   serial_adc_readout_port dut (.clk_i(clk_i), .rst_i(rst_i), .frame_sel_n_i(sel_n),
      .sclk_i(sclk), .analog_code_i(code), .sample_out_line_o(line),
      .sample_out_line_oe_n_o(oe_n), .hold_o(hold), .shutdown_o(shut), .powered_o(pwr));
   host_model host (.clk_i(clk_i), .line_i(line), .oe_n_i(oe_n), .sel_n_o(sel_n),
      .sclk_o(sclk));
   // One counted comparison
   task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic final_report;
      $display("compared %0d, mismatched %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Back-to-back full frames, extreme and mixed codes
   task automatic t_codes;
      logic [RES_W-1:0] tab [4] = '{12'h000, 12'hFFF, 12'hA5C, 12'h3A1};
      foreach (tab[i]) begin
         code = tab[i];
         host.frame(16, 1'b0, w);
         cmp("word", {4'h0, tab[i]}, w);
         cmp("oe_n", 16'h0001, {15'h0, oe_n});
         cmp("hold", 16'h0000, {15'h0, hold});
      end
   endtask
   // Clock idling high: first lead zero is not relied on
   task automatic t_first_fall;
      code = 12'h5A3;
      host.frame(16, 1'b1, w);
      cmp("tail", {4'h0, code}, {1'b0, w[14:0]});
   endtask
   // Select rise at the mode boundaries
   task automatic t_modes;
      int falls [6] = '{1, 2, 1, 9, 10, 12};
      logic sd [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      foreach (falls[i]) begin
         host.frame(falls[i], 1'b0, w);
         cmp("shutdown", {15'h0, sd[i]}, {15'h0, shut});
         cmp("oe_n", 16'h0001, {15'h0, oe_n});
      end
   endtask
   // Wake from shutdown: dummy frame first, then valid data
   task automatic t_wake;
      host.frame(3, 1'b0, w);
      cmp("powered", 16'h0000, {15'h0, pwr});
      host.frame(16, 1'b0, w);
      code = 12'h7E1;
      host.frame(16, 1'b0, w);
      cmp("powered", 16'h0001, {15'h0, pwr});
      cmp("word", {4'h0, code}, w);
   endtask
   // Main sequence; first frame after reset is a discarded dummy
   initial begin
      repeat (8) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      host.frame(16, 1'b0, w);
      t_codes();
      t_first_fall();
      t_modes();
      t_wake();
      final_report();
   end
   // Watchdog, well past the expected run length
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      final_report();
   end
endmodule
bind serial_adc_readout_port serial_adc_readout_port_assertions chk (.clk_i(clk_i),
   .rst_i(rst_i), .frame_sel_n_i(frame_sel_n_i), .sclk_i(sclk_i),
   .analog_code_i(analog_code_i), .sample_out_line_o(sample_out_line_o),
   .sample_out_line_oe_n_o(sample_out_line_oe_n_o), .hold_o(hold_o),
   .shutdown_o(shutdown_o), .powered_o(powered_o));
